// [cadf_addr_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module cadf_addr_decode
(
  // request address
  input  wire logic [39:0] addr,
  // decoded kind
  output wire logic        is_type0,
  output wire logic        is_type1,
  // decoded fields
  output wire logic [7:0]  bus_num,
  output wire logic [4:0]  dev_num,
  output wire logic [2:0]  func_num,
  output wire logic [5:0]  reg_num
);

  wire logic [15:0] prefix;

  assign prefix   = addr[cadf_pkg::PREFIX_MSB:cadf_pkg::PREFIX_LSB];
  assign is_type0 = (prefix == cadf_pkg::TYPE0_PREFIX);
  assign is_type1 = (prefix == cadf_pkg::TYPE1_PREFIX);
  assign bus_num  = is_type1 ? addr[cadf_pkg::BUS_MSB:cadf_pkg::BUS_LSB] : cadf_pkg::RSVD_BUS_FILL;
  assign dev_num  = addr[cadf_pkg::DEV_MSB:cadf_pkg::DEV_LSB];
  assign func_num = addr[cadf_pkg::FUNC_MSB:cadf_pkg::FUNC_LSB];
  assign reg_num  = addr[cadf_pkg::REG_MSB:cadf_pkg::REG_LSB];

endmodule

`default_nettype wire

// [cadf_config_node.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - type0 address: prefix FDFE in 39:24, device 15:11, function 10:8, register 7:2
// - type1 address: prefix FDFF in 39:24, bus number in 23:16, same low fields
// - node claims type0 by matching device number against its own numbers
// - double-ended host bridge answers secondary type0 at its programmed device number
// - bridges and sharing hosts forward type1 requests, upstream ones too
// - forwarders convert type1 to type0 on reaching the target bus, any direction
// - every implemented device number provides function 0 with its header
// - unit identifiers span 00h-1Fh; base unit identifier always implemented
// - other owned numbers optional; unimplemented ones never answered
// - access nobody accepts gets answer with error and nonexistent flag set
// - host registers on bus 0 sit at upper device numbers, never device 0
// - unit identifier 0 reserved for host; never owned by a node
// - host bridge may deliver special cycles via type1 device 31 function 7 register 0
module cadf_config_node
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // incoming configuration request
  input  wire logic        req_valid,
  input  wire logic        req_is_read,
  input  wire logic        req_posted,
  input  wire logic        req_upstream,
  input  wire logic        req_on_secondary,
  input  wire logic [3:0]  req_dw_count,
  input  wire logic [39:0] req_addr,
  // node identity and role
  input  wire logic [4:0]  base_unit_identifier,
  input  wire logic [4:0]  unit_count,
  input  wire logic [31:0] impl_mask,
  input  wire logic [7:0]  func_impl_mask,
  input  wire logic        is_forwarder,
  input  wire logic        is_host_bridge,
  input  wire logic        double_ended_en,
  input  wire logic [4:0]  host_dev_num,
  input  wire logic        special_cycle_en,
  input  wire logic        chain_end,
  input  wire logic [7:0]  secondary_bus,
  input  wire logic [7:0]  subordinate_bus,
  // local claim
  output logic             claim_valid_ff,
  output logic             claim_is_read_ff,
  output logic [4:0]       claim_dev_ff,
  output logic [2:0]       claim_func_ff,
  output logic [5:0]       claim_reg_ff,
  output logic             claim_func_present_ff,
  // forwarded request
  output logic             fwd_valid_ff,
  output logic             fwd_is_read_ff,
  output logic             fwd_upstream_ff,
  output logic             fwd_converted_ff,
  output logic [39:0]      fwd_addr_ff,
  // special cycle delivery
  output logic             special_valid_ff,
  output logic [7:0]       special_bus_ff,
  // error answer
  output logic             resp_valid_ff,
  output logic             resp_error_ff,
  output logic             resp_nonexist_ff,
  // dropped posted write
  output logic             drop_posted_ff
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic        is_type0;
  wire logic        is_type1;
  wire logic [7:0]  bus_num;
  wire logic [4:0]  dev_num;
  wire logic [2:0]  func_num;
  wire logic [5:0]  reg_num;

  cadf_addr_decode cadf_addr_decode_i
  (
    .addr     (req_addr),
    .is_type0 (is_type0),
    .is_type1 (is_type1),
    .bus_num  (bus_num),
    .dev_num  (dev_num),
    .func_num (func_num),
    .reg_num  (reg_num)
  );

  // ----------------------------------------------------------------
  // unit ownership
  // ----------------------------------------------------------------
  wire logic        dev_owned;
  wire logic        dev_impl;

  cadf_unit_match cadf_unit_match_i
  (
    .dev_num              (dev_num),
    .base_unit_identifier (base_unit_identifier),
    .unit_count           (unit_count),
    .impl_mask            (impl_mask),
    .owned                (dev_owned),
    .implemented          (dev_impl)
  );

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  wire logic        is_cfg;
  wire logic        take;
  wire logic        posted_drop;
  wire logic        too_long;
  wire logic        legal;

  assign is_cfg      = is_type0 || is_type1;
  assign take        = req_valid && is_cfg;
  assign posted_drop = take && req_posted && !req_is_read;
  assign too_long    = take && !posted_drop && (req_dw_count > cadf_pkg::MAX_DW_COUNT);
  assign legal       = take && !posted_drop && !too_long;

  // ----------------------------------------------------------------
  // type0 claim
  // ----------------------------------------------------------------
  wire logic        host_dev_ok;
  wire logic        host_claim;
  wire logic        node_claim;
  wire logic        local_claim;
  wire logic        func_present;

  assign host_dev_ok  = (host_dev_num != cadf_pkg::HOST_UNIT_ID);
  assign host_claim   = is_host_bridge && double_ended_en && req_on_secondary &&
                        host_dev_ok && (dev_num == host_dev_num);
  assign node_claim   = !req_upstream && dev_impl && dev_owned;
  assign local_claim  = legal && is_type0 && (host_claim || node_claim);
  assign func_present = (func_num == cadf_pkg::HEADER_FUNC) || func_impl_mask[func_num];

  // ----------------------------------------------------------------
  // type1 routing
  // ----------------------------------------------------------------
  wire logic        at_target;
  wire logic        below;
  wire logic        is_special;
  wire logic        special_hit;
  wire logic        convert;
  wire logic        pass_t1;
  wire logic        pass_t0;
  wire logic        any_fwd;
  wire logic        nobody;
  wire logic [39:0] conv_addr;

  assign at_target   = (bus_num == secondary_bus);
  assign below       = (bus_num > secondary_bus) && (bus_num <= subordinate_bus);
  assign is_special  = (dev_num == cadf_pkg::SPECIAL_DEV) && (func_num == cadf_pkg::SPECIAL_FUNC) &&
                       (reg_num == cadf_pkg::SPECIAL_REG);
  assign special_hit = legal && is_type1 && is_host_bridge && special_cycle_en && is_special && at_target;
  assign convert     = legal && is_type1 && is_forwarder && at_target && !special_hit;
  assign pass_t1     = legal && is_type1 && !special_hit && !convert &&
                       (is_forwarder ? below : !chain_end);
  assign pass_t0     = legal && is_type0 && !local_claim && !chain_end;
  assign any_fwd     = convert || pass_t1 || pass_t0;
  assign nobody      = legal && !local_claim && !any_fwd && !special_hit;
  assign conv_addr   = {cadf_pkg::TYPE0_PREFIX, cadf_pkg::RSVD_BUS_FILL,
                        req_addr[cadf_pkg::DEV_MSB:0]};

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  wire logic        nxt_claim_valid;
  wire logic        nxt_claim_is_read;
  wire logic [4:0]  nxt_claim_dev;
  wire logic [2:0]  nxt_claim_func;
  wire logic [5:0]  nxt_claim_reg;
  wire logic        nxt_claim_func_present;
  wire logic        nxt_fwd_valid;
  wire logic        nxt_fwd_is_read;
  wire logic        nxt_fwd_upstream;
  wire logic        nxt_fwd_converted;
  wire logic [39:0] nxt_fwd_addr;
  wire logic        nxt_special_valid;
  wire logic [7:0]  nxt_special_bus;
  wire logic        nxt_resp_valid;
  wire logic        nxt_resp_error;
  wire logic        nxt_resp_nonexist;
  wire logic        nxt_drop_posted;

  // claim side: fields follow the request every cycle, valid only on a claim
  assign nxt_claim_valid        = local_claim;
  assign nxt_claim_is_read      = req_is_read;
  assign nxt_claim_dev          = dev_num;
  assign nxt_claim_func         = func_num;
  assign nxt_claim_reg          = reg_num;
  assign nxt_claim_func_present = func_present;

  // forward side: converted requests carry the rebuilt type0 address
  assign nxt_fwd_valid          = any_fwd;
  assign nxt_fwd_is_read        = req_is_read;
  assign nxt_fwd_upstream       = req_upstream;
  assign nxt_fwd_converted      = convert;
  assign nxt_fwd_addr           = convert ? conv_addr : req_addr;

  // special and error side: a long access is an error without the nonexistent flag
  assign nxt_special_valid      = special_hit;
  assign nxt_special_bus        = bus_num;
  assign nxt_resp_valid         = nobody || too_long;
  assign nxt_resp_error         = nobody || too_long;
  assign nxt_resp_nonexist      = nobody;
  assign nxt_drop_posted        = posted_drop;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      claim_valid_ff        <= cadf_pkg::RST_PULSE;
      claim_is_read_ff      <= cadf_pkg::RST_PULSE;
      claim_dev_ff          <= cadf_pkg::UNIT_ID_MIN;
      claim_func_ff         <= cadf_pkg::HEADER_FUNC;
      claim_reg_ff          <= cadf_pkg::SPECIAL_REG;
      claim_func_present_ff <= cadf_pkg::RST_PULSE;
    end
    else
    begin
      claim_valid_ff        <= nxt_claim_valid;
      claim_is_read_ff      <= nxt_claim_is_read;
      claim_dev_ff          <= nxt_claim_dev;
      claim_func_ff         <= nxt_claim_func;
      claim_reg_ff          <= nxt_claim_reg;
      claim_func_present_ff <= nxt_claim_func_present;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fwd_valid_ff     <= cadf_pkg::RST_PULSE;
      fwd_is_read_ff   <= cadf_pkg::RST_PULSE;
      fwd_upstream_ff  <= cadf_pkg::RST_PULSE;
      fwd_converted_ff <= cadf_pkg::RST_PULSE;
      fwd_addr_ff      <= cadf_pkg::RST_ADDR;
    end
    else
    begin
      fwd_valid_ff     <= nxt_fwd_valid;
      fwd_is_read_ff   <= nxt_fwd_is_read;
      fwd_upstream_ff  <= nxt_fwd_upstream;
      fwd_converted_ff <= nxt_fwd_converted;
      fwd_addr_ff      <= nxt_fwd_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      special_valid_ff <= cadf_pkg::RST_PULSE;
      special_bus_ff   <= cadf_pkg::RSVD_BUS_FILL;
    end
    else
    begin
      special_valid_ff <= nxt_special_valid;
      special_bus_ff   <= nxt_special_bus;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      resp_valid_ff    <= cadf_pkg::RST_PULSE;
      resp_error_ff    <= cadf_pkg::RST_PULSE;
      resp_nonexist_ff <= cadf_pkg::RST_PULSE;
      drop_posted_ff   <= cadf_pkg::RST_PULSE;
    end
    else
    begin
      resp_valid_ff    <= nxt_resp_valid;
      resp_error_ff    <= nxt_resp_error;
      resp_nonexist_ff <= nxt_resp_nonexist;
      drop_posted_ff   <= nxt_drop_posted;
    end
  end

endmodule

`default_nettype wire

// [cadf_config_node_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module cadf_node_chk
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // request
  input  wire logic        req_valid,
  input  wire logic        req_is_read,
  input  wire logic        req_posted,
  input  wire logic        req_upstream,
  input  wire logic [3:0]  req_dw_count,
  input  wire logic [39:0] req_addr,
  // answers
  input  wire logic        claim_valid_ff,
  input  wire logic [4:0]  claim_dev_ff,
  input  wire logic        fwd_valid_ff,
  input  wire logic        fwd_upstream_ff,
  input  wire logic        fwd_converted_ff,
  input  wire logic [39:0] fwd_addr_ff,
  input  wire logic        special_valid_ff,
  input  wire logic        resp_valid_ff,
  input  wire logic        resp_error_ff,
  input  wire logic        resp_nonexist_ff,
  input  wire logic        drop_posted_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // request with either configuration prefix
  wire logic cfg_req = req_valid && req_addr[39:25] == 15'h7EFF;

  property p_one_answer;
    cfg_req |=> $onehot({claim_valid_ff, fwd_valid_ff, special_valid_ff, resp_valid_ff, drop_posted_ff});
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("answer count wrong");

  property p_claim;
    claim_valid_ff |-> $past(req_addr[39:24]) == 16'hFDFE && claim_dev_ff == $past(req_addr[15:11]);
  endproperty
  a_claim: assert property (p_claim) else $error("claim mismatch");

  property p_uid0;
    claim_valid_ff |-> claim_dev_ff != 5'h00;
  endproperty
  a_uid0: assert property (p_uid0) else $error("device 0 claimed");

  property p_convert;
    fwd_valid_ff && fwd_converted_ff |-> $past(req_addr[39:24]) == 16'hFDFF
      && fwd_addr_ff == {16'hFDFE, 8'h00, $past(req_addr[15:0])};
  endproperty
  a_convert: assert property (p_convert) else $error("bad conversion");

  property p_forward;
    fwd_valid_ff |-> fwd_upstream_ff == $past(req_upstream) && (fwd_converted_ff || fwd_addr_ff == $past(req_addr));
  endproperty
  a_forward: assert property (p_forward) else $error("bad forward");

  property p_posted;
    cfg_req && req_posted && !req_is_read && req_dw_count == 4'h0 |=> drop_posted_ff;
  endproperty
  a_posted: assert property (p_posted) else $error("posted write kept");

  property p_long;
    cfg_req && !req_posted && req_dw_count != 4'h0 |=> resp_valid_ff && resp_error_ff && !resp_nonexist_ff;
  endproperty
  a_long: assert property (p_long) else $error("long access kept");

  property p_nonexist;
    resp_nonexist_ff |-> resp_valid_ff && resp_error_ff && $past(cfg_req);
  endproperty
  a_nonexist: assert property (p_nonexist) else $error("bad nonexistent answer");

  c_claim: cover property (claim_valid_ff);
  c_convert: cover property (fwd_valid_ff && fwd_converted_ff);
  c_nonexist: cover property (resp_nonexist_ff);
endmodule

bind cadf_config_node cadf_node_chk cadf_node_chk_i (.*);

`default_nettype wire

// [cadf_link_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module cadf_link_peer
(
  // clock
  input  wire logic        clk_sys,
  // request toward the node
  output var logic         req_valid,
  output var logic         req_is_read,
  output var logic         req_posted,
  output var logic         req_upstream,
  output var logic         req_on_secondary,
  output var logic [3:0]   req_dw_count,
  output var logic [39:0]  req_addr
);
  initial
  begin
    req_valid = 1'b0;
    req_is_read = 1'b0;
    req_posted = 1'b0;
    req_upstream = 1'b0;
    req_on_secondary = 1'b0;
    req_dw_count = 4'h0;
    req_addr = 40'h00_0000_0000;
  end

  // ------------------------------------------------------------
  // one request for one cycle, then valid drops and address, count and read flag are driven inverted
  // ------------------------------------------------------------
  task automatic send(input logic [39:0] a, input logic rd, input logic pst, input logic up,
                      input logic sec, input logic [3:0] n);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_addr <= a;
    req_is_read <= rd;
    req_posted <= pst && !rd;
    req_upstream <= up && a[24];
    req_on_secondary <= sec;
    req_dw_count <= n;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_addr <= ~a;
    req_dw_count <= ~n;
    req_is_read <= ~rd;
  endtask
endmodule

`default_nettype wire

// [cadf_pkg.sv]
`default_nettype none

package cadf_pkg;

  // ----------------------------------------------------------------
  // configuration address layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 40;
  localparam int unsigned PREFIX_MSB    = 39;
  localparam int unsigned PREFIX_LSB    = 24;
  localparam int unsigned BUS_MSB       = 23;
  localparam int unsigned BUS_LSB       = 16;
  localparam int unsigned DEV_MSB       = 15;
  localparam int unsigned DEV_LSB       = 11;
  localparam int unsigned FUNC_MSB      = 10;
  localparam int unsigned FUNC_LSB      = 8;
  localparam int unsigned REG_MSB       = 7;
  localparam int unsigned REG_LSB       = 2;

  localparam logic [15:0] TYPE0_PREFIX  = 16'hFDFE;
  localparam logic [15:0] TYPE1_PREFIX  = 16'hFDFF;
  localparam logic [7:0]  RSVD_BUS_FILL = 8'h00;

  // ----------------------------------------------------------------
  // unit identifiers and device numbers
  // ----------------------------------------------------------------
  localparam logic [4:0]  UNIT_ID_MIN   = 5'h00;
  localparam logic [4:0]  UNIT_ID_MAX   = 5'h1F;
  localparam logic [4:0]  HOST_UNIT_ID  = 5'h00;
  localparam logic [2:0]  HEADER_FUNC   = 3'h0;

  // ----------------------------------------------------------------
  // special cycle target
  // ----------------------------------------------------------------
  localparam logic [4:0]  SPECIAL_DEV   = 5'h1F;
  localparam logic [2:0]  SPECIAL_FUNC  = 3'h7;
  localparam logic [5:0]  SPECIAL_REG   = 6'h00;

  // ----------------------------------------------------------------
  // sized request length: doubleword count minus one
  // ----------------------------------------------------------------
  localparam logic [3:0]  MAX_DW_COUNT  = 4'h0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        RST_PULSE     = 1'b0;
  localparam logic [39:0] RST_ADDR      = 40'h00_0000_0000;

endpackage

`default_nettype wire

// [cadf_unit_match.sv]
`timescale 1ns/1ps
`default_nettype none

module cadf_unit_match
(
  // device number under test
  input  wire logic [4:0]  dev_num,
  // node identity
  input  wire logic [4:0]  base_unit_identifier,
  input  wire logic [4:0]  unit_count,
  input  wire logic [31:0] impl_mask,
  // result
  output wire logic        owned,
  output wire logic        implemented
);

  wire logic [5:0]  offset;
  wire logic        base_valid;
  wire logic [31:0] dev_onehot;

  // unit identifier zero belongs to the host, never to a node
  assign base_valid  = (base_unit_identifier != cadf_pkg::HOST_UNIT_ID);
  assign offset      = {1'b0, dev_num} - {1'b0, base_unit_identifier};
  assign dev_onehot  = 32'h0000_0001 << dev_num;
  assign owned       = base_valid && (dev_num >= base_unit_identifier) &&
                       (offset < {1'b0, unit_count}) && (dev_num != cadf_pkg::HOST_UNIT_ID);
  // base device number always implemented; others only where enabled
  assign implemented = owned && ((dev_num == base_unit_identifier) || ((impl_mask & dev_onehot) != 32'h0000_0000));

endmodule

`default_nettype wire

// [test_config_access_decode_forward.sv]
`timescale 1ns/1ps
`default_nettype none

module test_config_access_decode_forward;
  logic        clk_sys, rstn, is_forwarder, is_host_bridge, double_ended_en, special_cycle_en, chain_end;
  logic [4:0]  base_unit_identifier, unit_count, host_dev_num, claim_dev_ff;
  logic [7:0]  func_impl_mask, secondary_bus, subordinate_bus, special_bus_ff;
  logic [31:0] impl_mask;
  logic        req_valid, req_is_read, req_posted, req_upstream, req_on_secondary;
  logic [3:0]  req_dw_count;
  logic [39:0] req_addr, fwd_addr_ff;
  logic        claim_valid_ff, claim_is_read_ff, claim_func_present_ff, fwd_valid_ff, fwd_is_read_ff;
  logic        fwd_upstream_ff, fwd_converted_ff, special_valid_ff, resp_valid_ff, resp_error_ff;
  logic        resp_nonexist_ff, drop_posted_ff;
  logic [2:0]  claim_func_ff;
  logic [5:0]  claim_reg_ff;
  int          num_errors = 0;
  int          n_compared = 0;

  cadf_config_node cadf_config_node_i (.*);
  cadf_link_peer   cadf_link_peer_i (.*);

  always #5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [39:0] ca(input logic t1, input logic [7:0] b, input logic [4:0] d,
                                     input logic [2:0] f, input logic [5:0] r);
    return {15'h7EFF, t1, b, d, f, r, 2'b00};
  endfunction

  task automatic rq(input logic [39:0] a, input logic rd = 1'b1, input logic pst = 1'b0,
                    input logic up = 1'b0, input logic sec = 1'b0, input logic [3:0] n = 4'h0);
    cadf_link_peer_i.send(a, rd, pst, up, sec, n);
    #1;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic fw(input logic [7:0] b, input logic up, input logic [2:0] e);
    // upstream requests are reads here, so the read flag is seen both ways
    rq(ca(1'b1, b, 5'h09, 3'h3, 6'h11), up, 1'b0, up);
    chk({fwd_valid_ff, fwd_converted_ff, fwd_upstream_ff, fwd_is_read_ff, resp_nonexist_ff}, {e, up, 1'b0});
    if (e[1])
      chk(fwd_addr_ff, ca(1'b0, 8'h00, 5'h09, 3'h3, 6'h11));
    else
      chk(fwd_addr_ff, ca(1'b1, b, 5'h09, 3'h3, 6'h11));
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_claim;
    rq(ca(1'b0, 8'hA5, 5'h04, 3'h0, 6'h05));
    chk({claim_valid_ff, claim_is_read_ff, claim_func_present_ff}, 3'h7);
    chk({claim_dev_ff, claim_func_ff, claim_reg_ff}, {5'h04, 3'h0, 6'h05});
    rq(ca(1'b0, 8'h00, 5'h06, 3'h2, 6'h3F), 1'b0);
    chk({claim_valid_ff, claim_is_read_ff, claim_func_present_ff, claim_dev_ff}, {3'h4, 5'h06});
    rq(ca(1'b0, 8'h00, 5'h05, 3'h0, 6'h00));
    chk({claim_valid_ff, resp_valid_ff, resp_error_ff, resp_nonexist_ff}, 4'h7);
    $display("claim test done");
  endtask

  task automatic t_host;
    @(posedge clk_sys);
    is_host_bridge <= 1'b1;
    double_ended_en <= 1'b1;
    rq(ca(1'b0, 8'h00, 5'h1E, 3'h1, 6'h02), 1'b1, 1'b0, 1'b0, 1'b1);
    chk({claim_valid_ff, claim_dev_ff, claim_func_ff}, {1'b1, 5'h1E, 3'h1});
    rq(ca(1'b0, 8'h00, 5'h1E, 3'h1, 6'h02));
    chk({claim_valid_ff, resp_nonexist_ff}, 2'h1);
    @(posedge clk_sys);
    host_dev_num <= 5'h00;
    rq(ca(1'b0, 8'h00, 5'h00, 3'h0, 6'h00), 1'b1, 1'b0, 1'b0, 1'b1);
    chk({claim_valid_ff, resp_nonexist_ff}, 2'h1);
    $display("host test done");
  endtask

  task automatic t_fwd;
    @(posedge clk_sys);
    is_host_bridge <= 1'b0;
    double_ended_en <= 1'b0;
    is_forwarder <= 1'b1;
    chain_end <= 1'b0;
    fw(8'h03, 1'b1, 3'h5);
    fw(8'h05, 1'b0, 3'h4);
    fw(8'h02, 1'b1, 3'h7);
    fw(8'h02, 1'b0, 3'h6);
    rq(ca(1'b1, 8'h06, 5'h09, 3'h3, 6'h11));
    chk({fwd_valid_ff, resp_error_ff, resp_nonexist_ff}, 3'h3);
    $display("forward test done");
  endtask

  task automatic t_special;
    @(posedge clk_sys);
    is_host_bridge <= 1'b1;
    special_cycle_en <= 1'b1;
    rq(ca(1'b1, 8'h02, 5'h1F, 3'h7, 6'h00), 1'b0);
    chk({special_valid_ff, fwd_valid_ff, special_bus_ff}, {2'h2, 8'h02});
    $display("special test done");
  endtask

  task automatic t_refuse;
    @(posedge clk_sys);
    is_host_bridge <= 1'b0;
    special_cycle_en <= 1'b0;
    is_forwarder <= 1'b0;
    chain_end <= 1'b1;
    rq(ca(1'b0, 8'h00, 5'h04, 3'h0, 6'h01), 1'b0, 1'b1);
    chk({drop_posted_ff, claim_valid_ff, resp_valid_ff}, 3'h4);
    rq(ca(1'b0, 8'h00, 5'h04, 3'h0, 6'h01), 1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
    chk({resp_valid_ff, resp_error_ff, resp_nonexist_ff, claim_valid_ff}, 4'hC);
    @(posedge clk_sys);
    base_unit_identifier <= 5'h00;
    rq(ca(1'b0, 8'h00, 5'h00, 3'h0, 6'h00));
    chk({claim_valid_ff, resp_nonexist_ff}, 2'h1);
    $display("refuse test done");
  endtask

  initial
  begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    base_unit_identifier = 5'h04;
    unit_count = 5'h03;
    impl_mask = 32'h0000_0050;
    func_impl_mask = 8'h01;
    is_forwarder = 1'b0;
    is_host_bridge = 1'b0;
    double_ended_en = 1'b0;
    host_dev_num = 5'h1E;
    special_cycle_en = 1'b0;
    chain_end = 1'b1;
    secondary_bus = 8'h02;
    subordinate_bus = 8'h05;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_claim;
    t_host;
    t_fwd;
    t_special;
    t_refuse;
    end_sim;
  end

  initial
  begin
    #3000;
    num_errors++;
    end_sim;
  end
endmodule

`default_nettype wire
